// ---- rtl/cel_comparator_event.sv ----
// Top of the comparator event logic: APB registers, source select, sync, edge flag, capture.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module cel_comparator_event
  import cel_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk, // System clock, 25 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic pin_above_neg, // Analog core: positive pin above negative pin.
  input wire logic ref_above_neg, // Analog core: internal reference above negative pin.
  input wire logic cpu_global_irq_enable, // Processor global interrupt enable.
  input wire logic irq_vector_ack, // Pulse when the processor takes the vector.
  output logic comparator_power_off, // Power-down request to the analog core.
  output logic reference_input_select, // Positive source select to the analog core.
  output logic capture_trigger, // Comparator level into the timer capture logic.
  output logic comparator_irq_request, // Comparator vector request to the processor.
  output logic irq // Level interrupt from unmasked status bits.
);

  // ==========================================================================
  // Parameter checks.
  // ==========================================================================
  if (ADDR_W < 8)
  begin : g_bad_addr
    $error("cel_comparator_event decodes paddr[7:0] and needs at least eight address bits");
  end

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  logic power_off_reg;
  logic ref_select_reg;
  logic irq_flag_reg;
  logic irq_flag_next;
  logic irq_enable_reg;
  logic capture_route_reg;
  logic [1:0] edge_mode_reg;
  logic [CEL_EVT_COUNT-1:0] irq_status_reg;
  logic [CEL_EVT_COUNT-1:0] irq_status_next;
  logic [CEL_EVT_COUNT-1:0] irq_mask_reg;
  logic [CEL_EVT_COUNT-1:0] irq_events;
  logic raw_result;
  logic comparator_sync_out;
  logic edge_event;
  logic change_event;
  logic [7:0] local_addr;
  logic hit_csr;
  logic hit_status;
  logic hit_mask;
  logic addr_mapped;
  logic setup_phase;
  logic access_done;
  logic wr_csr;
  logic wr_status;
  logic wr_mask;
  logic flag_w1c;
  logic [31:0] read_mux;
  logic [7:0] csr_view;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic capture_trigger_reg;
  logic irq_request_reg;
  logic irq_reg;

  // ==========================================================================
  // APB decode.
  // ==========================================================================
  assign local_addr = paddr[7:0];
  assign hit_csr = (local_addr == CEL_CSR_OFFSET);
  assign hit_status = (local_addr == CEL_IRQ_STATUS_OFFSET);
  assign hit_mask = (local_addr == CEL_IRQ_MASK_OFFSET);
  assign addr_mapped = hit_csr | hit_status | hit_mask;
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_reg;
  assign wr_csr = access_done & pwrite & hit_csr;
  assign wr_status = access_done & pwrite & hit_status;
  assign wr_mask = access_done & pwrite & hit_mask;

  // ==========================================================================
  // APB response.
  // ==========================================================================
  // Ready is raised in the first access cycle, so every transfer has no wait
  // states; read data and error are captured in the setup cycle from the
  // address held stable by the master, which keeps all bus outputs on flops.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup_phase;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pslverr_reg <= 1'b0;
    end
    else if (setup_phase)
    begin
      pslverr_reg <= ~addr_mapped;
    end
    else
    begin
      pslverr_reg <= 1'b0;
    end
  end

  always_comb
  begin
    csr_view = 8'h00;
    csr_view[CEL_BIT_POWER_OFF] = power_off_reg;
    csr_view[CEL_BIT_REF_SELECT] = ref_select_reg;
    csr_view[CEL_BIT_SYNC_OUT] = comparator_sync_out;
    csr_view[CEL_BIT_IRQ_FLAG] = irq_flag_reg;
    csr_view[CEL_BIT_IRQ_ENABLE] = irq_enable_reg;
    csr_view[CEL_BIT_CAPTURE_ROUTE] = capture_route_reg;
    csr_view[CEL_BIT_EDGE_HI] = edge_mode_reg[1];
    csr_view[CEL_BIT_EDGE_LO] = edge_mode_reg[0];
  end

  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (hit_csr)
    begin
      read_mux = {24'h00_0000, csr_view};
    end
    else if (hit_status)
    begin
      read_mux = {30'h0000_0000, irq_status_reg};
    end
    else if (hit_mask)
    begin
      read_mux = {30'h0000_0000, irq_mask_reg};
    end
    else
    begin
      read_mux = 32'h0000_0000;
    end
  end

  // Read data is sampled one cycle before the master takes it, so the live
  // output bit may lag the synchroniser by one more cycle on a read.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
    end
    else if (setup_phase && !pwrite)
    begin
      prdata_reg <= read_mux;
    end
    else
    begin
      prdata_reg <= 32'h0000_0000;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // ==========================================================================
  // Control fields.
  // ==========================================================================
  // power off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_off_reg <= CEL_CSR_RESET[CEL_BIT_POWER_OFF];
    end
    else if (wr_csr)
    begin
      power_off_reg <= pwdata[CEL_BIT_POWER_OFF];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_select_reg <= CEL_CSR_RESET[CEL_BIT_REF_SELECT];
    end
    else if (wr_csr)
    begin
      ref_select_reg <= pwdata[CEL_BIT_REF_SELECT];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_enable_reg <= CEL_CSR_RESET[CEL_BIT_IRQ_ENABLE];
    end
    else if (wr_csr)
    begin
      irq_enable_reg <= pwdata[CEL_BIT_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_route_reg <= CEL_CSR_RESET[CEL_BIT_CAPTURE_ROUTE];
    end
    else if (wr_csr)
    begin
      capture_route_reg <= pwdata[CEL_BIT_CAPTURE_ROUTE];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      edge_mode_reg <= CEL_CSR_RESET[CEL_BIT_EDGE_HI:CEL_BIT_EDGE_LO];
    end
    else if (wr_csr)
    begin
      edge_mode_reg <= pwdata[CEL_BIT_EDGE_HI:CEL_BIT_EDGE_LO];
    end
  end

  // ==========================================================================
  // Comparator result path.
  // ==========================================================================
  // selected source result
  // reference or pin
  // A powered-down comparator reads low. Switching power or source can make
  // the result jump, which is why software masks the interrupt first.
  // relies on masking
  assign raw_result = power_off_reg ? 1'b0 : (ref_select_reg ? ref_above_neg : pin_above_neg);

  cel_sync #(
    .STAGES(CEL_SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(raw_result),
    .q(comparator_sync_out)
  );

  cel_edge_detect u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .sample(comparator_sync_out),
    .mode(edge_mode_reg),
    .event_pulse(edge_event),
    .change_pulse(change_event)
  );

  // ==========================================================================
  // Comparator interrupt flag.
  // ==========================================================================
  assign flag_w1c = wr_csr & pwdata[CEL_BIT_IRQ_FLAG];

  // A new edge wins over a clear arriving in the same cycle.
  always_comb
  begin
    irq_flag_next = irq_flag_reg;
    if (flag_w1c || irq_vector_ack)
    begin
      irq_flag_next = 1'b0;
    end
    if (edge_event)
    begin
      irq_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_flag_reg <= CEL_CSR_RESET[CEL_BIT_IRQ_FLAG];
    end
    else
    begin
      irq_flag_reg <= irq_flag_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_request_reg <= 1'b0;
    end
    else
    begin
      irq_request_reg <= irq_flag_next & irq_enable_reg & cpu_global_irq_enable;
    end
  end

  // ==========================================================================
  // Timer capture route.
  // ==========================================================================
  // gated route
  // With the route off the capture input sits low, so the timer sees no edges.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_trigger_reg <= 1'b0;
    end
    else
    begin
      capture_trigger_reg <= capture_route_reg & comparator_sync_out;
    end
  end

  // ==========================================================================
  // Sticky event status, mask and interrupt line.
  // ==========================================================================
  always_comb
  begin
    irq_events = '0;
    irq_events[CEL_EVT_EDGE_MATCH] = edge_event;
    irq_events[CEL_EVT_OUT_CHANGE] = change_event;
  end

  // Write-one clears; an event in the same cycle keeps its bit set.
  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (wr_status)
    begin
      irq_status_next = irq_status_reg & ~pwdata[CEL_EVT_COUNT-1:0];
    end
    irq_status_next = irq_status_next | irq_events;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status_reg <= CEL_IRQ_RESET;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_mask_reg <= CEL_IRQ_RESET;
    end
    else if (wr_mask)
    begin
      irq_mask_reg <= pwdata[CEL_EVT_COUNT-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(irq_status_next & irq_mask_reg);
    end
  end

  // ==========================================================================
  // Outputs to the analog core, timer and processor.
  // ==========================================================================
  // Power and source select come straight from their control flops.
  assign comparator_power_off = power_off_reg;
  assign reference_input_select = ref_select_reg;
  assign capture_trigger = capture_trigger_reg;
  assign comparator_irq_request = irq_request_reg;
  assign irq = irq_reg;

endmodule

// ---- rtl/cel_edge_detect.sv ----
// Edge detector that matches the synchronised result against the edge mode.
`timescale 1ns/1ps
module cel_edge_detect
  import cel_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic sample, // Synchronised comparator level.
  input wire logic [1:0] mode, // Edge mode code.
  output logic event_pulse, // One-cycle pulse on a matching edge.
  output logic change_pulse // One-cycle pulse on any change.
);

  logic prev_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_reg <= 1'b0;
    end
    else
    begin
      prev_reg <= sample;
    end
  end

  assign change_pulse = sample ^ prev_reg;

  always_comb
  begin
    case (mode)
      CEL_MODE_TOGGLE: event_pulse = change_pulse;
      CEL_MODE_FALLING: event_pulse = prev_reg & ~sample;
      CEL_MODE_RISING: event_pulse = sample & ~prev_reg;
      CEL_MODE_RESERVED: event_pulse = 1'b0;
      default: event_pulse = 1'b0;
    endcase
  end

endmodule

// ---- rtl/cel_pkg.sv ----
// Package with register map, field positions and mode codes of the comparator event logic.
package cel_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB).
  // ==========================================================================
  localparam logic [7:0] CEL_CSR_OFFSET = 8'h00;
  localparam logic [7:0] CEL_IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CEL_IRQ_MASK_OFFSET = 8'h08;

  // ==========================================================================
  // Control/status register bit positions.
  // ==========================================================================
  localparam int CEL_BIT_POWER_OFF = 7;
  localparam int CEL_BIT_REF_SELECT = 6;
  localparam int CEL_BIT_SYNC_OUT = 5;
  localparam int CEL_BIT_IRQ_FLAG = 4;
  localparam int CEL_BIT_IRQ_ENABLE = 3;
  localparam int CEL_BIT_CAPTURE_ROUTE = 2;
  localparam int CEL_BIT_EDGE_HI = 1;
  localparam int CEL_BIT_EDGE_LO = 0;

  // ==========================================================================
  // Reset values.
  // ==========================================================================
  localparam logic [7:0] CEL_CSR_RESET = 8'h00;
  localparam logic [1:0] CEL_IRQ_RESET = 2'h0;

  // ==========================================================================
  // Interrupt status bits.
  // ==========================================================================
  localparam int CEL_EVT_EDGE_MATCH = 0;
  localparam int CEL_EVT_OUT_CHANGE = 1;
  localparam int CEL_EVT_COUNT = 2;

  // ==========================================================================
  // Edge mode codes.
  // ==========================================================================
  localparam logic [1:0] CEL_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] CEL_MODE_RESERVED = 2'h1;
  localparam logic [1:0] CEL_MODE_FALLING = 2'h2;
  localparam logic [1:0] CEL_MODE_RISING = 2'h3;

  // Synchroniser depth giving the one to two cycle latency.
  localparam int CEL_SYNC_STAGES = 2;

endpackage

// ---- rtl/cel_sync.sv ----
// Multi-stage level synchroniser for the comparator result.
`timescale 1ns/1ps
module cel_sync
  import cel_pkg::*;
#(
  parameter int STAGES = CEL_SYNC_STAGES
)
(
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic d, // Level from the analog side.
  output logic q // Synchronised level.
);

  logic [STAGES-1:0] chain_reg;

  if (STAGES < 2)
  begin : g_bad_stages
    $error("cel_sync needs at least two stages");
  end

  // Only the next stage reads each flop before the last, so no logic sees a metastable value.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chain_reg <= '0;
    end
    else
    begin
      chain_reg <= {chain_reg[STAGES-2:0], d};
    end
  end

  assign q = chain_reg[STAGES-1];

endmodule

// ---- tb/cel_analog_model.sv ----
// Behavioural analog comparator core facing the event block.
`timescale 1ns/1ps
module cel_analog_model
#(
  parameter int SETTLE = 4
)
(
  input wire logic clk, // Clock.
  input wire logic comparator_power_off, // Power down.
  input wire logic reference_input_select, // Source select.
  input wire logic [15:0] pos_mv, // Positive pin level.
  input wire logic [15:0] neg_mv, // Negative pin level.
  input wire logic [15:0] ref_mv, // Reference level.
  output logic pin_above_neg, // Pin result.
  output logic ref_above_neg // Reference result.
);
  logic junk = 1'b0;
  int settle_cnt = 0;
  always @(posedge clk)
  begin
    junk <= ~junk;
    if (!reference_input_select)
      settle_cnt <= SETTLE;
    else if (settle_cnt > 0)
      settle_cnt <= settle_cnt - 1;
  end
  // powered-off core gives no trustworthy result.
  assign pin_above_neg = comparator_power_off ? junk : (pos_mv > neg_mv);
  assign ref_above_neg = comparator_power_off ? junk : ((ref_mv > neg_mv) ^ (settle_cnt != 0));
endmodule

// ---- tb/cel_ev_assertions.sv ----
// Port checker for the comparator event block, bound to its top.
`timescale 1ns/1ps
module cel_ev_assertions
  import cel_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic psel, // Bus.
  input wire logic penable, // Bus.
  input wire logic pwrite, // Bus.
  input wire logic [ADDR_W-1:0] paddr, // Bus.
  input wire logic [31:0] pwdata, // Bus.
  input wire logic [31:0] prdata, // Bus.
  input wire logic pready, // Bus.
  input wire logic pslverr, // Bus.
  input wire logic pin_above_neg, // Analog.
  input wire logic ref_above_neg, // Analog.
  input wire logic cpu_global_irq_enable, // Cpu.
  input wire logic irq_vector_ack, // Cpu.
  input wire logic comparator_power_off, // Analog.
  input wire logic reference_input_select, // Analog.
  input wire logic capture_trigger, // Timer.
  input wire logic comparator_irq_request, // Cpu.
  input wire logic irq // Interrupt.
);
  logic raw;
  logic csr_wr;
  logic mapped;
  logic [1:0] wr_ctl;
  // The level the block samples, rebuilt from the outputs that steer the analog core.
  assign raw = !comparator_power_off &&
    (reference_input_select ? ref_above_neg : pin_above_neg);
  assign csr_wr = pready && pwrite && paddr == ADDR_W'(CEL_CSR_OFFSET);
  assign mapped = paddr == ADDR_W'(CEL_CSR_OFFSET) || paddr == ADDR_W'(CEL_IRQ_STATUS_OFFSET) ||
    paddr == ADDR_W'(CEL_IRQ_MASK_OFFSET);
  assign wr_ctl = pwdata[7:6];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // Properties
  // ==========================================================================
  sequence setup_phase;
    psel && !penable;
  endsequence
  sequence quiet_raw;
    $past(raw, 2) == $past(raw, 3);
  endsequence

  a_ready_setup: assert property (setup_phase |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_error_decode: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_read_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero when idle");
  a_ctl_write: assert property (
    csr_wr |=> {comparator_power_off, reference_input_select} == $past(wr_ctl))
    else $error("control bits not written");
  a_ctl_hold: assert property (
    $changed(comparator_power_off) || $changed(reference_input_select) |-> $past(csr_wr))
    else $error("control bits changed without write");
  a_capture_cause: assert property (capture_trigger |-> $past(raw, 3))
    else $error("capture high without comparator level");
  a_request_global: assert property (
    comparator_irq_request |-> $past(cpu_global_irq_enable))
    else $error("request without global enable");
  a_ack_clears: assert property (
    irq_vector_ack ##0 quiet_raw |=> !comparator_irq_request)
    else $error("request kept after vector taken");
endmodule

bind cel_comparator_event cel_ev_assertions #(.ADDR_W(ADDR_W)) u_chk
(
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_above_neg(pin_above_neg), .ref_above_neg(ref_above_neg),
  .cpu_global_irq_enable(cpu_global_irq_enable), .irq_vector_ack(irq_vector_ack),
  .comparator_power_off(comparator_power_off), .reference_input_select(reference_input_select),
  .capture_trigger(capture_trigger), .comparator_irq_request(comparator_irq_request), .irq(irq)
);

// ---- tb/testbench.sv ----
// Self-checking bench for the comparator event block.
`timescale 1ns/1ps
module testbench
  import cel_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_above_neg;
  logic ref_above_neg;
  logic glob_en = 1'b0;
  logic ack = 1'b0;
  logic power_off;
  logic ref_sel;
  logic capture;
  logic request;
  logic irq;
  logic [15:0] pos_mv = 16'h0000;
  logic [15:0] neg_mv = 16'h01F4;
  logic [15:0] ref_mv = 16'h0000;
  logic [31:0] q;
  logic e;
  int n_fail = 0;
  int comparisons = 0;

  always #20 clk = ~clk;

  cel_comparator_event #(.ADDR_W(8)) u_dut
  (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_above_neg(pin_above_neg), .ref_above_neg(ref_above_neg),
    .cpu_global_irq_enable(glob_en), .irq_vector_ack(ack),
    .comparator_power_off(power_off), .reference_input_select(ref_sel),
    .capture_trigger(capture), .comparator_irq_request(request), .irq(irq)
  );

  cel_analog_model u_core
  (
    .clk(clk), .comparator_power_off(power_off), .reference_input_select(ref_sel),
    .pos_mv(pos_mv), .neg_mv(neg_mv), .ref_mv(ref_mv),
    .pin_above_neg(pin_above_neg), .ref_above_neg(ref_above_neg)
  );

  // ==========================================================================
  // Bus and compare tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 16);
    if (n >= 16)
      n_fail++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, q);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    rd(CEL_CSR_OFFSET, 32'h0000_0000, "csr");
    rd(CEL_IRQ_STATUS_OFFSET, 32'h0000_0000, "status");
    rd(CEL_IRQ_MASK_OFFSET, 32'h0000_0000, "mask");
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    chk("slverr", 32'h0000_0001, {31'h0000_0000, e});
    rd(8'h0C, 32'h0000_0000, "unmapped");
    chk("outs", 32'h0000_0000, {27'h000_0000, power_off, ref_sel, capture, request, irq});
  endtask

  task automatic t_modes();
    logic [31:0] ctl;
    logic rh;
    logic fh;
    for (int i = 0; i < 4; i++)
    begin
      ctl = i;
      rh = (ctl[1:0] == CEL_MODE_TOGGLE) || (ctl[1:0] == CEL_MODE_RISING);
      fh = (ctl[1:0] == CEL_MODE_TOGGLE) || (ctl[1:0] == CEL_MODE_FALLING);
      apb(1'b1, CEL_CSR_OFFSET, ctl);
      apb(1'b1, CEL_CSR_OFFSET, ctl | 32'h0000_0010);
      apb(1'b1, CEL_IRQ_STATUS_OFFSET, 32'h0000_0003);
      pos_mv <= 16'h0384;
      cyc(5);
      rd(CEL_CSR_OFFSET, ctl | 32'h0000_0020 | {27'h000_0000, rh, 4'h0}, "rise");
      pos_mv <= 16'h0000;
      cyc(5);
      rd(CEL_CSR_OFFSET, ctl | {27'h000_0000, rh | fh, 4'h0}, "fall");
      rd(CEL_IRQ_STATUS_OFFSET, {30'h0000_0000, 1'b1, rh | fh}, "status");
      apb(1'b1, CEL_CSR_OFFSET, ctl);
      rd(CEL_CSR_OFFSET, ctl | {27'h000_0000, rh | fh, 4'h0}, "kept");
      apb(1'b1, CEL_CSR_OFFSET, ctl | 32'h0000_0010);
      rd(CEL_CSR_OFFSET, ctl, "cleared");
      apb(1'b1, CEL_IRQ_STATUS_OFFSET, 32'h0000_0001);
      rd(CEL_IRQ_STATUS_OFFSET, 32'h0000_0002, "status w1c");
    end
  endtask

  task automatic t_irq();
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_0003);
    apb(1'b1, CEL_IRQ_STATUS_OFFSET, 32'h0000_0003);
    apb(1'b1, CEL_IRQ_MASK_OFFSET, 32'h0000_0001);
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_000B);
    pos_mv <= 16'h0384;
    cyc(5);
    chk("request", 32'h0000_0000, {31'h0000_0000, request});
    chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
    glob_en <= 1'b1;
    cyc(2);
    chk("request", 32'h0000_0001, {31'h0000_0000, request});
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_0003);
    cyc(2);
    chk("request", 32'h0000_0000, {31'h0000_0000, request});
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_000B);
    cyc(2);
    chk("request", 32'h0000_0001, {31'h0000_0000, request});
    apb(1'b1, CEL_IRQ_MASK_OFFSET, 32'h0000_0000);
    cyc(2);
    chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
    apb(1'b1, CEL_IRQ_MASK_OFFSET, 32'h0000_0003);
    apb(1'b1, CEL_IRQ_STATUS_OFFSET, 32'h0000_0003);
    cyc(2);
    chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
    rd(CEL_IRQ_MASK_OFFSET, 32'h0000_0003, "mask");
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    cyc(2);
    chk("request", 32'h0000_0000, {31'h0000_0000, request});
    rd(CEL_CSR_OFFSET, 32'h0000_002B, "acked");
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_0003);
    pos_mv <= 16'h0000;
  endtask

  task automatic t_route();
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_0001);
    pos_mv <= 16'h0384;
    cyc(5);
    chk("capture", 32'h0000_0000, {31'h0000_0000, capture});
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_0005);
    cyc(3);
    chk("capture", 32'h0000_0001, {31'h0000_0000, capture});
    pos_mv <= 16'h0000;
    cyc(5);
    chk("capture", 32'h0000_0000, {31'h0000_0000, capture});
    ref_mv <= 16'h0384;
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_0041);
    cyc(10);
    rd(CEL_CSR_OFFSET, 32'h0000_0061, "reference");
    chk("ref select", 32'h0000_0001, {31'h0000_0000, ref_sel});
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_00C1);
    cyc(4);
    chk("power off", 32'h0000_0001, {31'h0000_0000, power_off});
    rd(CEL_CSR_OFFSET, 32'h0000_00C1, "powered off");
    apb(1'b1, CEL_CSR_OFFSET, 32'h0000_0001);
    cyc(1);
    chk("power on", 32'h0000_0000, {31'h0000_0000, power_off});
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    t_route();
    test_done();
  end

  // The whole sequence needs well under a thousand cycles.
  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    test_done();
  end
endmodule
